/* src/aux_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aux_ctrl_regs.svh"
module aux_ctrl
  import aux_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        wr_crc_bad,
  output logic      [15:0] reg_rdata,
  // Serial read framing
  input  wire logic        read_lsb_edge,
  input  wire logic        cs_rise,
  output logic             if_reset,
  output logic             hold_lsb,
  // General pins
  input  wire logic [1:0]  gp_in,
  output logic      [1:0]  gp_out,
  output logic      [1:0]  gp_oe,
  // Sync / error pin
  input  wire logic        sync_err_in,
  output logic             sync_err_out,
  output logic             sync_err_oe,
  // Converter core
  input  wire logic        fast_filter,
  input  wire logic        rate_below_10k,
  input  wire logic        rate_no_absorb,
  input  wire logic [15:0] conv_cycles,
  input  wire logic [23:0] core_raw,
  input  wire logic        core_over,
  input  wire logic        core_under,
  input  wire logic        core_done,
  input  wire logic [1:0]  core_channel,
  input  wire logic        multi_channel,
  output logic             filter_reset,
  output logic             conv_start,
  output logic             absorb_delay,
  output logic             step_channel,
  // Result stream
  output logic      [23:0] result_data,
  output logic      [7:0]  result_status,
  output logic             result_append,
  output logic             ready_n
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0]     conv_mode;
    logic [15:0]     if_mode;
    logic [15:0]     pin_cfg;
    logic            err_conv;
    logic            err_crc;
    logic            err_reg;
    logic [15:0]     chk_ref;
    logic            sync_q;
    aux_conv_state_t st;
    logic [15:0]     cnt;
    logic [3:0]      rst_cnt;
    logic            hold;
    logic            ifr;
    logic [23:0]     data;
    logic [1:0]      chan;
    logic            rdy_n;
  } aux_state_t;

  aux_state_t cur;
  aux_state_t next_s;
  logic [15:0] dly_cyc;
  logic [23:0] fmt_data;
  logic [15:0] chk_now;
  logic        sync_en;
  logic        restart;
  logic        fault_in;
  aux_err_mode_t err_mode;

  aux_delay_table u_dly (
    .dly_sel    (cur.conv_mode[`AUX_DLY_LSB+2:`AUX_DLY_LSB]),
    .dly_cycles (dly_cyc)
  );
  aux_result_fmt u_fmt (
    .raw                (core_raw),
    .over               (core_over),
    .under              (core_under),
    .short_result_width (cur.if_mode[`AUX_SHORT_BIT]),
    .result             (fmt_data)
  );

  // ------------------------------------------------------------
  // Combinational
  // ------------------------------------------------------------
  assign sync_en  = cur.pin_cfg[`AUX_SYNC_EN_BIT];
  assign restart  = cur.if_mode[`AUX_RESTART_BIT];
  assign err_mode = aux_err_mode_t'(cur.pin_cfg[`AUX_ERR_EN_LSB+1:`AUX_ERR_EN_LSB]);
  // Config checksum excludes status, data and interface mode
  // Pin-driven data bits are left out, or a live pin would flag a change
  assign chk_now  = cur.conv_mode ^ {cur.pin_cfg[15:9], 3'b000, cur.pin_cfg[5:0]};
  assign fault_in = sync_en && !restart && err_mode == aux_err_input && !sync_err_in;

  always_comb begin
    next_s = cur;
    conv_start = 1'b0;
    step_channel = 1'b0;
    absorb_delay = 1'b0;
    // Registers
    if (reg_wr && !wr_crc_bad) begin
      case (reg_addr)
        `AUX_CONV_MODE_ADDR: next_s.conv_mode = reg_wdata;
        `AUX_IF_MODE_ADDR:   next_s.if_mode = reg_wdata;
        `AUX_PIN_CFG_ADDR:   next_s.pin_cfg = reg_wdata;
        default: ;
      endcase
    end
    // Error flags: set beats clear
    next_s.err_conv = core_over || core_under || fault_in;
    if (reg_rd && reg_addr == `AUX_STATUS_ADDR) begin
      next_s.err_crc = 1'b0;
    end
    if (reg_wr && wr_crc_bad) begin
      next_s.err_crc = 1'b1;
    end
    if (!cur.if_mode[`AUX_REGCHK_BIT]) begin
      next_s.err_reg = 1'b0;
      next_s.chk_ref = chk_now;
    end else if (chk_now != cur.chk_ref) begin
      next_s.err_reg = 1'b1;
    end
    // A config write wins, so a stale pin level never survives a mode change
    if (!(reg_wr && reg_addr == `AUX_PIN_CFG_ADDR)) begin
      if (err_mode == aux_err_input) begin
        next_s.pin_cfg[`AUX_FAULT_PIN_LEVEL_BIT] = sync_err_in;
      end
      // Pin input data bits
      if (cur.pin_cfg[`AUX_IE0_BIT]) next_s.pin_cfg[`AUX_IE0_BIT+4] = gp_in[0];
      if (cur.pin_cfg[`AUX_IE1_BIT]) next_s.pin_cfg[`AUX_IE1_BIT+4] = gp_in[1];
    end
    // Read-end interface reset
    next_s.sync_q = sync_err_in;
    next_s.ifr = 1'b0;
    if (read_lsb_edge) begin
      next_s.hold = cur.if_mode[`AUX_DOUT_RST_BIT];
      next_s.rst_cnt = cur.if_mode[`AUX_DOUT_RST_BIT] ? 4'h0 : 4'(`AUX_READ_RST_CYC);
    end else if (cur.rst_cnt != 4'h0) begin
      next_s.rst_cnt = cur.rst_cnt - 4'h1;
      next_s.ifr = cur.rst_cnt == 4'h1;
    end
    if (cur.hold && cs_rise) begin
      next_s.hold = 1'b0;
      next_s.ifr = 1'b1;
    end
    // Conversion sequencing
    if (core_done) begin
      next_s.rdy_n = 1'b0;
      next_s.data = fmt_data;
      next_s.chan = core_channel;
    end else if (reg_rd || conv_start) begin
      next_s.rdy_n = 1'b1;
    end
    case (cur.st)
      aux_idle: begin
        if (sync_en && !restart && !sync_err_in) begin
          next_s.st = aux_held;
        end else if (sync_en && restart && multi_channel && !sync_err_in) begin
          next_s.st = aux_park;
        end else begin
          next_s.st = aux_delay;
          next_s.cnt = dly_cyc;
        end
      end
      aux_held: begin
        if (sync_err_in) begin
          next_s.st = aux_delay;
          next_s.cnt = dly_cyc;
        end
      end
      aux_delay: begin
        if (!fast_filter || cur.cnt == 16'h0000) begin
          next_s.st = aux_conv;
          conv_start = 1'b1;
        end else if (!cur.if_mode[`AUX_EXTEND_BIT] && rate_below_10k && !rate_no_absorb
                     && {cur.cnt, 1'b0} < {1'b0, conv_cycles}) begin
          next_s.st = aux_conv;
          conv_start = 1'b1;
        end else begin
          next_s.cnt = cur.cnt - 16'h0001;
        end
      end
      aux_conv: begin
        absorb_delay = !cur.if_mode[`AUX_EXTEND_BIT] && rate_below_10k && !rate_no_absorb
                       && fast_filter && dly_cyc != 16'h0000;
        if (sync_en && !restart && !sync_err_in) begin
          next_s.st = aux_held;
        end else if (core_done) begin
          if (sync_en && restart && multi_channel && !sync_err_in) begin
            next_s.st = aux_park;
            step_channel = 1'b1;
          end else begin
            next_s.st = aux_delay;
            next_s.cnt = dly_cyc;
          end
        end
      end
      aux_park: begin
        if (sync_err_in) begin
          next_s.st = aux_delay;
          next_s.cnt = dly_cyc;
        end
      end
      default: next_s.st = aux_idle;
    endcase
  end

  // ------------------------------------------------------------
  // Register
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur <= '0;
      cur.conv_mode <= `AUX_CONV_MODE_RST;
      cur.if_mode <= `AUX_IF_MODE_RST;
      cur.pin_cfg <= `AUX_PIN_CFG_RST;
      cur.rdy_n <= 1'b1;
      cur.sync_q <= 1'b1;
    end else begin
      cur <= next_s;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign filter_reset = cur.st == aux_held;
  assign if_reset = cur.ifr;
  assign hold_lsb = cur.hold;
  assign ready_n = cur.rdy_n;
  assign result_data = cur.data;
  assign result_status = {cur.rdy_n, cur.err_conv, cur.err_crc, cur.err_reg, 2'b00, cur.chan};
  assign result_append = cur.if_mode[`AUX_APPEND_BIT];
  assign gp_oe = {cur.pin_cfg[`AUX_OE1_BIT], cur.pin_cfg[`AUX_OE0_BIT]};
  assign gp_out = {cur.pin_cfg[`AUX_OUT1_BIT], cur.pin_cfg[`AUX_OUT0_BIT]};

  always_comb begin
    sync_err_out = 1'b0;
    sync_err_oe = 1'b0;
    if (sync_en && !restart) begin
      case (err_mode)
        aux_err_gpo: begin
          sync_err_out = cur.pin_cfg[`AUX_FAULT_PIN_LEVEL_BIT];
          sync_err_oe = 1'b1;
        end
        aux_err_output: begin
          sync_err_oe = cur.err_conv || cur.err_crc || cur.err_reg;
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    case (reg_addr)
      `AUX_STATUS_ADDR:    reg_rdata = {8'h00, result_status};
      `AUX_CONV_MODE_ADDR: reg_rdata = cur.conv_mode;
      `AUX_IF_MODE_ADDR:   reg_rdata = cur.if_mode;
      `AUX_PIN_CFG_ADDR:   reg_rdata = cur.pin_cfg;
      default:             reg_rdata = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

/* src/aux_ctrl_regs.svh */
// What this block does
// - Pin set as input shows its live level in its input data bit.
// - Pin set as output drives the level held in its output data bit.
// - Fault pin field 11 with sync on, restart off makes the pin a general output following its data bit.
// - Three-bit delay field picks one of eight pre-sample waits, fast filter only.
// - Nonzero delay with extend bit set lengthens every conversion by the delay.
// - Extend clear, delay under half conversion, rate below 10k: delay absorbed.
// - Rates 397.5, 59.94, 49.96 and 16.66 SPS never absorb a delay.
// - Results are 24 bits; short width bit rounds them to 16 bits.
// - Reset-select 0: interface resets a fixed time after the last read edge.
// - Reset-select 1: LSB keeps driving; interface resets on select rising edge.
// - Sync enabled, restart off and pin low holds modulator and filter reset, config kept.
// - Leave sync reset on first clock edge after pin rises, resume sampling.
// - As a trigger, sync rising edge starts conversion; done goes low when settled.
// - Per-channel restart: low pin finishes channel, steps channel, waits for rise.
// - Conversion error set on over/undervoltage with railed result; clears with fault.
// - Checksum error set on bad write checksum; clears on explicit status read.
// - Register check watches config checksum; change sets error; clearing bit clears.
// - Field 10 with sync on, restart off: open drain drives inverted OR of errors.
// - Field 01: pin input, inverted level ORed into conversion error with sync on, restart off, shown in data.
// - Status appending follows each result with status; low two bits give channel.
`ifndef AUX_CTRL_REGS_SVH
`define AUX_CTRL_REGS_SVH
`define AUX_STATUS_ADDR     6'h00
`define AUX_CONV_MODE_ADDR  6'h01
`define AUX_IF_MODE_ADDR    6'h02
`define AUX_PIN_CFG_ADDR    6'h06
`define AUX_CONV_MODE_RST   16'h8000
`define AUX_IF_MODE_RST     16'h0000
`define AUX_PIN_CFG_RST     16'h0000
`define AUX_DLY_LSB         8
`define AUX_EXTEND_BIT      10
`define AUX_RESTART_BIT     12
`define AUX_DOUT_RST_BIT    8
`define AUX_APPEND_BIT      6
`define AUX_REGCHK_BIT      5
`define AUX_SHORT_BIT       0
`define AUX_SYNC_EN_BIT     11
`define AUX_ERR_EN_LSB      9
`define AUX_FAULT_PIN_LEVEL_BIT     8
`define AUX_OE1_BIT         5
`define AUX_OE0_BIT         4
`define AUX_IE1_BIT         3
`define AUX_IE0_BIT         2
`define AUX_OUT1_BIT        1
`define AUX_OUT0_BIT        0
`define AUX_CLK_MHZ         10
`define AUX_READ_RST_NS     100
`define AUX_READ_RST_CYC    ((`AUX_READ_RST_NS*`AUX_CLK_MHZ+999)/1000)
`define AUX_DLY_MAX_US      1000
`define AUX_DLY_MAX_CYC     (`AUX_DLY_MAX_US*`AUX_CLK_MHZ)
`define AUX_ABSORB_MAX_SPS  10000
`endif

/* src/aux_ctrl_pkg.sv */
package aux_ctrl_pkg;
  typedef enum logic [1:0] {
    aux_err_off    = 2'b00,
    aux_err_input  = 2'b01,
    aux_err_output = 2'b10,
    aux_err_gpo    = 2'b11
  } aux_err_mode_t;
  typedef enum logic [2:0] {
    aux_idle   = 3'b000,
    aux_held   = 3'b001,
    aux_delay  = 3'b010,
    aux_conv   = 3'b011,
    aux_park   = 3'b100
  } aux_conv_state_t;
endpackage

/* src/aux_delay_table.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aux_ctrl_regs.svh"
module aux_delay_table
  import aux_ctrl_pkg::*;
(
  // Selection
  input  wire logic [2:0]  dly_sel,
  // Wait in clock cycles
  output logic      [15:0] dly_cycles
);
  always_comb begin
    case (dly_sel)
      3'h0:    dly_cycles = 16'h0000;
      3'h1:    dly_cycles = 16'(4*`AUX_CLK_MHZ);
      3'h2:    dly_cycles = 16'(16*`AUX_CLK_MHZ);
      3'h3:    dly_cycles = 16'(40*`AUX_CLK_MHZ);
      3'h4:    dly_cycles = 16'(100*`AUX_CLK_MHZ);
      3'h5:    dly_cycles = 16'(200*`AUX_CLK_MHZ);
      3'h6:    dly_cycles = 16'(500*`AUX_CLK_MHZ);
      default: dly_cycles = 16'(`AUX_DLY_MAX_CYC);
    endcase
  end
endmodule
`default_nettype wire

/* src/aux_result_fmt.sv */
`timescale 1ns/1ps
`default_nettype none
`include "aux_ctrl_regs.svh"
module aux_result_fmt
  import aux_ctrl_pkg::*;
(
  // Raw result
  input  wire logic [23:0] raw,
  input  wire logic        over,
  input  wire logic        under,
  input  wire logic        short_result_width,
  // Formatted result, left-justified
  output logic      [23:0] result
);
  logic [23:0] railed;
  logic [16:0] rounded;
  always_comb begin
    railed = over ? 24'hffffff : (under ? 24'h000000 : raw);
    rounded = {1'b0, railed[23:8]} + {16'h0000, railed[7]};
    if (!short_result_width) begin
      result = railed;
    end else begin
      // Saturate so rounding never wraps full scale to zero
      result = {(rounded[16] ? 16'hffff : rounded[15:0]), 8'h00};
    end
  end
endmodule
`default_nettype wire

/* verif/aux_ctrl_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module aux_ctrl_properties
  import aux_ctrl_pkg::*;
(
  // Watched ports
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        reg_wr,
  input wire logic [5:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        wr_crc_bad,
  input wire logic        read_lsb_edge,
  input wire logic        cs_rise,
  input wire logic        if_reset,
  input wire logic        hold_lsb,
  input wire logic [1:0]  gp_out,
  input wire logic [1:0]  gp_oe,
  input wire logic        sync_err_in,
  input wire logic        filter_reset,
  input wire logic        rate_no_absorb,
  input wire logic        absorb_delay,
  input wire logic        core_done,
  input wire logic        core_over,
  input wire logic [1:0]  core_channel,
  input wire logic [23:0] result_data,
  input wire logic [7:0]  result_status
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_cfg_wr; reg_wr && reg_addr == 6'h06 && !wr_crc_bad; endsequence
  sequence s_lsb; read_lsb_edge && !hold_lsb; endsequence
  property p_gp_cfg;
    s_cfg_wr |=> gp_out == $past(reg_wdata[1:0]) && gp_oe == $past(reg_wdata[5:4]);
  endproperty
  a_gp_cfg: assert property (p_gp_cfg)
    else $error("pin config not applied");
  property p_rd_end; s_lsb |-> ##[1:3] (if_reset || hold_lsb); endproperty
  a_rd_end: assert property (p_rd_end)
    else $error("no interface reset after read");
  property p_hold_src; $rose(hold_lsb) |-> $past(read_lsb_edge); endproperty
  a_hold_src: assert property (p_hold_src)
    else $error("lsb hold without read end");
  property p_hold_keep; hold_lsb && !cs_rise |=> hold_lsb; endproperty
  a_hold_keep: assert property (p_hold_keep)
    else $error("lsb hold dropped early");
  property p_cs_rst; hold_lsb && cs_rise |=> if_reset; endproperty
  a_cs_rst: assert property (p_cs_rst)
    else $error("select rise did not reset");
  property p_sync_in; $rose(filter_reset) |-> $past(!sync_err_in); endproperty
  a_sync_in: assert property (p_sync_in)
    else $error("filter reset without low pin");
  property p_sync_out; filter_reset && sync_err_in |=> !filter_reset; endproperty
  a_sync_out: assert property (p_sync_out)
    else $error("filter reset not released");
  property p_rail; core_done && core_over |=> result_data[23:8] == 16'hffff; endproperty
  a_rail: assert property (p_rail)
    else $error("overrange result not railed");
  property p_chan; core_done |=> result_status[1:0] == $past(core_channel); endproperty
  a_chan: assert property (p_chan)
    else $error("status channel wrong");
  property p_no_abs; rate_no_absorb |-> !absorb_delay; endproperty
  a_no_abs: assert property (p_no_abs)
    else $error("delay absorbed at excluded rate");
endmodule
`default_nettype wire

/* verif/aux_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module aux_pin_model (
  // Bench requests
  input  wire logic       clock,
  input  wire logic       sync_req,
  input  wire logic       err_low,
  input  wire logic [1:0] gp_drive,
  // Device pins
  input  wire logic [1:0] gp_out,
  input  wire logic [1:0] gp_oe,
  input  wire logic       sync_err_out,
  input  wire logic       sync_err_oe,
  output logic      [1:0] gp_in,
  output logic            sync_err_in
);
  logic sync_low = 1'b0;
  // Moves only on a rising edge, so a low phase spans whole clocks
  always @(posedge clock) sync_low <= sync_req;
  always_comb begin
    gp_in = (gp_oe & gp_out) | (~gp_oe & gp_drive);
    // Pull-up wins when nobody drives
    sync_err_in = (sync_low || err_low) ? 1'b0 : (sync_err_oe ? sync_err_out : 1'b1);
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("FAIL %0t got %h exp %h", $time, a, e); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 60) begin @(negedge clock); n++; end \
  if (!(c)) begin fails++; close_out(); end end
module tb
  import aux_ctrl_pkg::*;
;
  logic        clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, wr_crc_bad = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000, conv_cycles = 16'hffff, reg_rdata, d;
  logic        read_lsb_edge = 1'b0, cs_rise = 1'b0, fast_filter = 1'b1, multi_channel = 1'b0;
  logic        rate_below_10k = 1'b1, rate_no_absorb = 1'b0, sync_req = 1'b0, err_low = 1'b0;
  logic        core_over = 1'b0, core_under = 1'b0, core_done = 1'b0;
  logic [23:0] core_raw = 24'h000000, result_data;
  logic [1:0]  core_channel = 2'h0, gp_drive = 2'h0, gp_in, gp_out, gp_oe;
  logic        if_reset, hold_lsb, sync_err_in, sync_err_out, sync_err_oe, filter_reset;
  logic        conv_start, absorb_delay, step_channel, result_append, ready_n;
  logic [7:0]  result_status;
  int          n, fails = 0, checked = 0;
  always #50 clock = ~clock;
  aux_ctrl uut (.*);
  aux_pin_model u_pins (.*);
  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] v, input logic bad);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    wr_crc_bad = bad;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    wr_crc_bad = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    #1 d = reg_rdata;
    @(negedge clock);
    reg_rd = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask
  task automatic s_reset();
    rd(6'h01); `CHK(d, 16'h8000)
    rd(6'h02); `CHK(d, 16'h0000)
    rd(6'h06); `CHK(d, 16'h0000)
    rd(6'h3f); `CHK(d, 16'h0000)
  endtask
  task automatic s_gpio();
    wr(6'h06, 16'h0032, 1'b0);
    `CHK(gp_oe, 2'b11)
    `CHK(gp_out, 2'b10)
    wr(6'h06, 16'h000c, 1'b0);
    for (int i = 1; i < 3; i++) begin
      gp_drive = i[1:0];
      repeat (3) @(negedge clock);
      rd(6'h06); `CHK(d[7:6], i[1:0])
    end
  endtask
  task automatic s_errpin();
    wr(6'h06, 16'h0c00, 1'b0);
    `CHK(sync_err_in, 1'b1)
    wr(6'h01, 16'h1234, 1'b1);
    rd(6'h01); `CHK(d, 16'h8000)
    `CHK(sync_err_in, 1'b0)
    rd(6'h00); `CHK(d[5], 1'b1)
    rd(6'h00); `CHK(d[5], 1'b0)
    `CHK(sync_err_in, 1'b1)
    wr(6'h06, 16'h0f00, 1'b0);
    `CHK(sync_err_in, 1'b1)
    wr(6'h06, 16'h0e00, 1'b0);
    `CHK(sync_err_in, 1'b0)
    wr(6'h06, 16'h0a00, 1'b0);
    err_low = 1'b1;
    repeat (3) @(negedge clock);
    rd(6'h00); `CHK(d[6], 1'b1)
    rd(6'h06); `CHK(d[8], 1'b0)
    err_low = 1'b0;
    repeat (3) @(negedge clock);
    rd(6'h00); `CHK(d[6], 1'b0)
  endtask
  task automatic s_readrst();
    pulse(read_lsb_edge);
    `WAITC(if_reset)
    `CHK(hold_lsb, 1'b0)
    wr(6'h02, 16'h0100, 1'b0);
    pulse(read_lsb_edge);
    repeat (4) @(negedge clock);
    `CHK(hold_lsb, 1'b1)
    pulse(cs_rise);
    `WAITC(if_reset)
    `CHK(hold_lsb, 1'b0)
    wr(6'h02, 16'h0000, 1'b0);
  endtask
  task automatic s_sync();
    wr(6'h06, 16'h0800, 1'b0);
    sync_req = 1'b1;
    `WAITC(filter_reset)
    repeat (3) @(negedge clock);
    `CHK(filter_reset, 1'b1)
    rd(6'h06); `CHK(d[15:8], 8'h08)
    sync_req = 1'b0;
    `WAITC(!filter_reset)
    `WAITC(conv_start)
    `CHK(conv_start, 1'b1)
    wr(6'h06, 16'h0000, 1'b0);
  endtask
  task automatic s_conv();
    wr(6'h02, 16'h0040, 1'b0);
    core_raw = 24'h1234a0;
    core_channel = 2'h2;
    pulse(core_done);
    `CHK(result_data, 24'h1234a0)
    `CHK(result_status[1:0], 2'h2)
    `CHK(result_append, 1'b1)
    `CHK(ready_n, 1'b0)
    wr(6'h02, 16'h0041, 1'b0);
    pulse(core_done);
    `CHK(result_data, 24'h123500)
    core_over = 1'b1;
    pulse(core_done);
    `CHK(result_data, 24'hffff00)
    rd(6'h00); `CHK(d[6], 1'b1)
    core_over = 1'b0;
    core_under = 1'b1;
    pulse(core_done);
    `CHK(result_data, 24'h000000)
    core_under = 1'b0;
  endtask
  task automatic s_regchk();
    wr(6'h02, 16'h0020, 1'b0);
    wr(6'h01, 16'h8100, 1'b0);
    rd(6'h00); `CHK(d[4], 1'b1)
    wr(6'h02, 16'h0000, 1'b0);
    rd(6'h00); `CHK(d[4], 1'b0)
  endtask
  task automatic s_delay();
    wr(6'h01, 16'h8100, 1'b0);
    `CHK(absorb_delay, 1'b1)
    rate_no_absorb = 1'b1;
    #1 `CHK(absorb_delay, 1'b0)
    rate_no_absorb = 1'b0;
    rate_below_10k = 1'b0;
    #1 `CHK(absorb_delay, 1'b0)
    rate_below_10k = 1'b1;
    wr(6'h02, 16'h0400, 1'b0);
    `CHK(absorb_delay, 1'b0)
  endtask
  task automatic s_restart();
    multi_channel = 1'b1;
    wr(6'h02, 16'h1000, 1'b0);
    wr(6'h06, 16'h0800, 1'b0);
    sync_req = 1'b1;
    repeat (3) @(negedge clock);
    `CHK(filter_reset, 1'b0)
    core_done = 1'b1;
    #1 `CHK(step_channel, 1'b1)
    @(negedge clock);
    core_done = 1'b0;
    repeat (3) @(negedge clock);
    `CHK(conv_start, 1'b0)
    sync_req = 1'b0;
    `WAITC(conv_start)
    `CHK(conv_start, 1'b1)
  endtask
  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    s_reset();
    s_gpio();
    s_errpin();
    s_readrst();
    s_sync();
    s_conv();
    s_regchk();
    s_delay();
    s_restart();
    close_out();
  end
endmodule
bind aux_ctrl aux_ctrl_properties u_props (.*);
`default_nettype wire
